// >>> rtl/mppb_bank.sv
// motion profile parameter bank: object access, offsets, set-point latch
// Function
// RULE_01: jerk at acceleration start, 32-bit, preset 3e8
// RULE_02: jerk at braking start, 32-bit, same preset
// RULE_03: jerk at acceleration and braking end
// RULE_04: position unit: unit, exponent, low half zero
// RULE_05: velocity unit: time, position, exponent fields
// RULE_06: position offset added only in csp
// RULE_07: velocity offset in csp, csv, clock-direction
// RULE_08: torque offset in cyclic and clock-direction modes
// RULE_09: interpolation set-point, signed 32-bit demand position
// RULE_10: set-point takes effect at next sync
// RULE_11: cycle time is value times ten^index
// RULE_12: master keeps time index at minus three
// RULE_13: time value 8-bit, preset one
// RULE_14: zero jerk means unlimited jerk
// RULE_15: presets loaded before any access accepted
`default_nettype none
module mppb_bank
   import mppb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire mppb_pkg::mppb_req_t od_req,
   output mppb_pkg::mppb_rsp_t od_rsp,
   input wire mppb_pkg::mppb_mode_t op_mode,
   input wire mppb_pkg::mppb_setv_t set_in,
   input wire logic sync_evt,
   output mppb_pkg::mppb_setv_t set_out,
   output logic [31:0] interp_target,
   output logic [3:0][31:0] jerk,
   output logic [3:0] jerk_unlim,
   output logic [31:0] pos_unit,
   output logic [31:0] vel_unit,
   output logic [7:0] time_val,
   output logic [7:0] time_idx,
   output logic [31:0] cycle_us,
   output logic cycle_ok,
   output logic bank_ready
);

   mppb_state_t st_reg;
   mppb_state_t st_next;
   mppb_sel_t sel;
   logic [31:0] rd_val;
   logic in_csp;
   logic in_vel_mode;
   logic in_tq_mode;

   // ***************************************************************
   // object decode, shared by read and write paths
   // ***************************************************************
   function automatic mppb_sel_t od_decode(input logic [15:0] idx, input logic [7:0] sub);
      od_decode = SEL_NONE;
      unique case (idx)
         IDX_JERK: begin
            if (sub == SUB_COUNT) begin
               od_decode = SEL_COUNT;
            end else if (sub <= SUB_JERK_LAST) begin
               od_decode = mppb_sel_t'(4'(SEL_JERK0) + 4'(sub - SUB_FIRST));
            end
         end
         IDX_POS_UNIT: od_decode = (sub == SUB_COUNT) ? SEL_PUNIT : SEL_NONE;
         IDX_VEL_UNIT: od_decode = (sub == SUB_COUNT) ? SEL_VUNIT : SEL_NONE;
         IDX_POS_OFF: od_decode = (sub == SUB_COUNT) ? SEL_POFF : SEL_NONE;
         IDX_VEL_OFF: od_decode = (sub == SUB_COUNT) ? SEL_VOFF : SEL_NONE;
         IDX_TQ_OFF: od_decode = (sub == SUB_COUNT) ? SEL_TOFF : SEL_NONE;
         IDX_SETPT: begin
            if (sub == SUB_COUNT) begin
               od_decode = SEL_COUNT;
            end else if (sub == SUB_FIRST) begin
               od_decode = SEL_SETPT;
            end
         end
         IDX_TIME: begin
            if (sub == SUB_COUNT) begin
               od_decode = SEL_COUNT;
            end else if (sub == SUB_FIRST) begin
               od_decode = SEL_TVAL;
            end else if (sub == SUB_SECOND) begin
               od_decode = SEL_TIDX;
            end
         end
         default: od_decode = SEL_NONE;
      endcase
   endfunction

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      sel = od_decode(od_req.index, od_req.sub);
      in_csp = (op_mode == MODE_CSP);
      in_vel_mode = in_csp || (op_mode == MODE_CSV) || (op_mode == MODE_CLKDIR);
      in_tq_mode = in_vel_mode || (op_mode == MODE_CST);
      rd_val = 32'h00000000;
      unique case (sel)
         SEL_COUNT: begin
            if (od_req.index == IDX_JERK) begin
               rd_val = {24'h000000, CNT_JERK};
            end else if (od_req.index == IDX_SETPT) begin
               rd_val = {24'h000000, CNT_SETPT};
            end else begin
               rd_val = {24'h000000, CNT_TIME};
            end
         end
         SEL_JERK0: rd_val = st_reg.jerk[0];
         SEL_JERK1: rd_val = st_reg.jerk[1];
         SEL_JERK2: rd_val = st_reg.jerk[2];
         SEL_JERK3: rd_val = st_reg.jerk[3];
         SEL_PUNIT: rd_val = st_reg.pos_unit;
         SEL_VUNIT: rd_val = st_reg.vel_unit;
         SEL_POFF: rd_val = st_reg.pos_off;
         SEL_VOFF: rd_val = st_reg.vel_off;
         SEL_TOFF: rd_val = {{16{st_reg.tq_off[15]}}, st_reg.tq_off};
         SEL_SETPT: rd_val = st_reg.setpt;
         SEL_TVAL: rd_val = {24'h000000, st_reg.time_val};
         SEL_TIDX: rd_val = {{24{st_reg.time_idx[7]}}, st_reg.time_idx};
         default: rd_val = 32'h00000000;
      endcase

      st_next = st_reg;
      st_next.rsp = '0;
      unique case (st_reg.phase)
         PH_INIT: begin
            // presets are already in place; requests this cycle are dropped
            st_next.phase = PH_RUN; // [RULE_15]
         end
         PH_RUN: begin
            if (od_req.wr ^ od_req.rd) begin
               st_next.rsp.ack = 1'b1;
               // count entries are read only; unknown objects abort
               st_next.rsp.abort = (sel == SEL_NONE) || (od_req.wr && sel == SEL_COUNT);
               if (od_req.rd) begin
                  st_next.rsp.rdata = rd_val;
               end
            end else if (od_req.wr && od_req.rd) begin
               st_next.rsp.ack = 1'b1;
               st_next.rsp.abort = 1'b1;
            end
            if (od_req.wr && !od_req.rd) begin
               unique case (sel)
                  SEL_JERK0: st_next.jerk[0] = od_req.wdata; // [RULE_01]
                  SEL_JERK1: st_next.jerk[1] = od_req.wdata; // [RULE_02]
                  SEL_JERK2: st_next.jerk[2] = od_req.wdata; // [RULE_03]
                  SEL_JERK3: st_next.jerk[3] = od_req.wdata; // [RULE_03]
                  SEL_PUNIT: st_next.pos_unit = od_req.wdata & POS_UNIT_KEEP; // [RULE_04]
                  SEL_VUNIT: st_next.vel_unit = od_req.wdata & VEL_UNIT_KEEP; // [RULE_05]
                  SEL_POFF: st_next.pos_off = od_req.wdata;
                  SEL_VOFF: st_next.vel_off = od_req.wdata;
                  SEL_TOFF: st_next.tq_off = od_req.wdata[15:0];
                  SEL_SETPT: st_next.setpt = od_req.wdata; // [RULE_09]
                  SEL_TVAL: st_next.time_val = od_req.wdata[7:0]; // [RULE_13]
                  SEL_TIDX: st_next.time_idx = od_req.wdata[7:0];
                  default: ;
               endcase
            end
         end
         default: st_next.phase = PH_INIT;
      endcase

      // a set-point only reaches the interpolator at the sync event
      if (sync_evt) begin
         st_next.interp_target = st_reg.setpt; // [RULE_10]
      end

      // signed wrap-around sums; saturation is left to the consumer
      st_next.set_out.pos = set_in.pos + (in_csp ? st_reg.pos_off : 32'h00000000); // [RULE_06]
      st_next.set_out.vel = set_in.vel + (in_vel_mode ? st_reg.vel_off : 32'h00000000); // [RULE_07]
      st_next.set_out.tq = set_in.tq + (in_tq_mode ? st_reg.tq_off : 16'h0000); // [RULE_08]

      for (int i = 0; i < JERK_COUNT; i++) begin
         st_next.jerk_unlim[i] = (st_reg.jerk[i] == 32'h00000000); // [RULE_14]
      end
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.phase <= PH_INIT;
         st_reg.jerk <= {JERK_COUNT{RST_JERK}}; // [RULE_15]
         st_reg.pos_unit <= RST_POS_UNIT;
         st_reg.vel_unit <= RST_VEL_UNIT;
         st_reg.pos_off <= RST_OFF32;
         st_reg.vel_off <= RST_OFF32;
         st_reg.tq_off <= RST_TQ_OFF;
         st_reg.setpt <= RST_SETPT;
         st_reg.time_val <= RST_TIME_VAL;
         st_reg.time_idx <= RST_TIME_IDX;
         st_reg.interp_target <= RST_SETPT;
      end else begin
         st_reg <= st_next;
      end
   end

   mppb_cycle_time u_cycle_time (
      .clk(clk),
      .rst_n(rst_n),
      .time_val(st_reg.time_val),
      .time_idx(st_reg.time_idx),
      .cycle_us(cycle_us),
      .cycle_ok(cycle_ok)
   );

   assign od_rsp = st_reg.rsp;
   assign set_out = st_reg.set_out;
   assign interp_target = st_reg.interp_target;
   assign jerk = st_reg.jerk;
   assign jerk_unlim = st_reg.jerk_unlim;
   assign pos_unit = st_reg.pos_unit;
   assign vel_unit = st_reg.vel_unit;
   assign time_val = st_reg.time_val;
   assign time_idx = st_reg.time_idx;
   assign bank_ready = (st_reg.phase == PH_RUN);

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence seq_jerk_write(int n);
      od_req.wr && !od_req.rd && bank_ready && od_req.index == IDX_JERK
         && od_req.sub == 8'(n + 1);
   endsequence

   chk_init_presets: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
      !bank_ready |-> (jerk[0] == RST_JERK && jerk[3] == RST_JERK && time_val == 8'h01
         && pos_unit == RST_POS_UNIT && vel_unit == RST_VEL_UNIT && !od_rsp.ack))
      else $error("preset missing or access answered before ready");

   chk_jerk_start: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
      seq_jerk_write(0) |=> (jerk[0] == $past(od_req.wdata) && od_rsp.ack && !od_rsp.abort))
      else $error("acceleration start jerk not written");

   chk_jerk_brake: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
      seq_jerk_write(1) |=> (jerk[1] == $past(od_req.wdata))
         ##1 jerk_unlim[1] == ($past(jerk[1]) == 32'h00000000))
      else $error("braking start jerk not written");

   chk_jerk_end: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
      seq_jerk_write(3) |=> (jerk[3] == $past(od_req.wdata) && $stable(jerk[2])))
      else $error("braking end jerk not written");

   chk_unit_reserved: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
      pos_unit[15:0] == 16'h0000 && vel_unit[7:0] == 8'h00)
      else $error("reserved unit bits not zero");

   chk_vel_unit_wr: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
      (od_req.wr && !od_req.rd && bank_ready && od_req.index == IDX_VEL_UNIT
         && od_req.sub == 8'h00) |=> vel_unit[31:8] == $past(od_req.wdata[31:8]))
      else $error("velocity unit fields not stored");

   chk_pos_offset: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
      bank_ready |=> set_out.pos == $past(set_in.pos)
         + ($past(op_mode) == MODE_CSP ? $past(st_reg.pos_off) : 32'h0))
      else $error("position offset applied in wrong mode");

   chk_vel_offset: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
      bank_ready && (op_mode == MODE_CST) |=> set_out.vel == $past(set_in.vel))
      else $error("velocity offset applied in torque mode");

   chk_tq_offset: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
      bank_ready && (op_mode == MODE_CLKDIR)
         |=> set_out.tq == 16'($past(set_in.tq) + $past(st_reg.tq_off)))
      else $error("torque offset missing in clock-direction mode");

   chk_sync_latch: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
      sync_evt |=> interp_target == $past(st_reg.setpt))
      else $error("set-point not latched at sync");

   chk_sync_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
      !sync_evt |=> $stable(interp_target))
      else $error("interpolator target moved without sync");

endmodule
`default_nettype wire

// >>> rtl/mppb_cycle_time.sv
// interpolation cycle time from time value and power-of-ten index
`default_nettype none
module mppb_cycle_time
   import mppb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] time_val,
   input wire logic [7:0] time_idx,
   output logic [31:0] cycle_us,
   output logic cycle_ok
);

   mppb_ct_state_t st_reg;
   mppb_ct_state_t st_next;
   logic signed [8:0] exp_us;

   function automatic logic [19:0] pow10(input logic [2:0] e);
      case (e)
         3'h0: pow10 = 20'h00001;
         3'h1: pow10 = 20'h0000a;
         3'h2: pow10 = 20'h00064;
         3'h3: pow10 = 20'h003e8;
         3'h4: pow10 = 20'h02710;
         3'h5: pow10 = 20'h186a0;
         default: pow10 = 20'hf4240;
      endcase
   endfunction

   // ***************************************************************
   // value * 10^index seconds, held in microseconds
   // ***************************************************************
   // only indices from -6 to 0 fit; anything else flags not ok
   always_comb begin
      exp_us = $signed({time_idx[7], time_idx}) + 9'(US_EXP_BIAS);
      st_next = st_reg;
      st_next.ok = (exp_us >= 9'sd0) && (exp_us <= 9'(US_EXP_MAX));
      if (st_next.ok) begin
         // widen first: a 20-bit product would wrap above index -3
         st_next.us = 32'(time_val) * 32'(pow10(exp_us[2:0])); // [RULE_11]
      end else begin
         st_next.us = 32'h00000000;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cycle_us = st_reg.us;
   assign cycle_ok = st_reg.ok;

   // with the index kept at -3 the value counts milliseconds
   chk_ms_cycle: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
      // the edge that releases reset still finds this register in reset
      $past(rst_n) && (time_idx == 8'hfd)
         |=> (cycle_ok && cycle_us == 32'($past(time_val)) * 32'd1000))
      else $error("cycle time not value times 1000 us at index -3");

endmodule
`default_nettype wire

// >>> shared/mppb_pkg.sv
// package for the motion profile parameter bank: object map, presets, carriers
`default_nettype none
package mppb_pkg;

   // ***************************************************************
   // object indices and subindices
   // ***************************************************************
   localparam logic [15:0] IDX_JERK = 16'h60a4;
   localparam logic [15:0] IDX_POS_UNIT = 16'h60a8;
   localparam logic [15:0] IDX_VEL_UNIT = 16'h60a9;
   localparam logic [15:0] IDX_POS_OFF = 16'h60b0;
   localparam logic [15:0] IDX_VEL_OFF = 16'h60b1;
   localparam logic [15:0] IDX_TQ_OFF = 16'h60b2;
   localparam logic [15:0] IDX_SETPT = 16'h60c1;
   localparam logic [15:0] IDX_TIME = 16'h60c2;
   localparam logic [7:0] SUB_COUNT = 8'h00;
   localparam logic [7:0] SUB_FIRST = 8'h01;
   localparam logic [7:0] SUB_SECOND = 8'h02;
   localparam logic [7:0] SUB_JERK_LAST = 8'h04;
   localparam logic [7:0] CNT_JERK = 8'h04;
   localparam logic [7:0] CNT_SETPT = 8'h01;
   localparam logic [7:0] CNT_TIME = 8'h02;

   // ***************************************************************
   // presets and field layout
   // ***************************************************************
   localparam logic [31:0] RST_JERK = 32'h000003e8;
   localparam logic [31:0] RST_POS_UNIT = 32'hff410000;
   localparam logic [31:0] RST_VEL_UNIT = 32'h00b44700;
   localparam logic [31:0] RST_OFF32 = 32'h00000000;
   localparam logic [15:0] RST_TQ_OFF = 16'h0000;
   localparam logic [31:0] RST_SETPT = 32'h00000000;
   localparam logic [7:0] RST_TIME_VAL = 8'h01;
   localparam logic [7:0] RST_TIME_IDX = 8'hfd;
   localparam logic [31:0] POS_UNIT_KEEP = 32'hffff0000;
   localparam logic [31:0] VEL_UNIT_KEEP = 32'hffffff00;
   localparam int JERK_COUNT = 4;
   localparam int US_EXP_BIAS = 6;
   localparam int US_EXP_MAX = 6;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [4:0] {
      MODE_CSP = 5'h01,
      MODE_CSV = 5'h02,
      MODE_CST = 5'h04,
      MODE_CLKDIR = 5'h08,
      MODE_OTHER = 5'h10
   } mppb_mode_t;

   typedef enum logic [1:0] {
      PH_INIT = 2'h1,
      PH_RUN = 2'h2
   } mppb_phase_t;

   typedef enum logic [3:0] {
      SEL_NONE, SEL_COUNT, SEL_JERK0, SEL_JERK1, SEL_JERK2, SEL_JERK3,
      SEL_PUNIT, SEL_VUNIT, SEL_POFF, SEL_VOFF, SEL_TOFF, SEL_SETPT,
      SEL_TVAL, SEL_TIDX
   } mppb_sel_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] index;
      logic [7:0] sub;
      logic [31:0] wdata;
   } mppb_req_t;

   typedef struct packed {
      logic ack;
      logic abort;
      logic [31:0] rdata;
   } mppb_rsp_t;

   typedef struct packed {
      logic [31:0] pos;
      logic [31:0] vel;
      logic [15:0] tq;
   } mppb_setv_t;

   typedef struct packed {
      mppb_phase_t phase;
      logic [3:0][31:0] jerk;
      logic [31:0] pos_unit;
      logic [31:0] vel_unit;
      logic [31:0] pos_off;
      logic [31:0] vel_off;
      logic [15:0] tq_off;
      logic [31:0] setpt;
      logic [7:0] time_val;
      logic [7:0] time_idx;
      logic [31:0] interp_target;
      mppb_setv_t set_out;
      logic [3:0] jerk_unlim;
      mppb_rsp_t rsp;
   } mppb_state_t;

   typedef struct packed {
      logic [31:0] us;
      logic ok;
   } mppb_ct_state_t;

endpackage
`default_nettype wire

// >>> test/mppb_bank_tb.sv
// self-checking bench for the motion profile parameter bank
`default_nettype none
module mppb_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mppb_pkg::*;

   // ***************************************************************
   // signals and instances
   // ***************************************************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sync_evt = 1'b0;
   mppb_mode_t op_mode = MODE_OTHER;
   mppb_setv_t set_in = '0;
   mppb_req_t od_req;
   mppb_rsp_t od_rsp;
   mppb_setv_t set_out;
   logic [31:0] interp_target, pos_unit, vel_unit, cycle_us;
   logic [3:0][31:0] jerk;
   logic [3:0] jerk_unlim;
   logic [7:0] time_val, time_idx;
   logic cycle_ok, bank_ready;
   int n_mismatch = 0;
   int tests_run = 0;
   int seed = 44;
   logic [32:0] exp_q [$];
   logic [4:0] modes [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03};

   mppb_master_model mst (.clk(clk), .od_req(od_req));
   mppb_bank uut (.clk(clk), .rst_n(rst_n), .od_req(od_req), .od_rsp(od_rsp),
      .op_mode(op_mode), .set_in(set_in), .sync_evt(sync_evt), .set_out(set_out),
      .interp_target(interp_target), .jerk(jerk), .jerk_unlim(jerk_unlim),
      .pos_unit(pos_unit), .vel_unit(vel_unit), .time_val(time_val),
      .time_idx(time_idx), .cycle_us(cycle_us), .cycle_ok(cycle_ok),
      .bank_ready(bank_ready));

   initial begin
      forever #10 clk = ~clk;
   end

   // ***************************************************************
   // checking
   // ***************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      if (n_mismatch == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // every ack takes the oldest note; an ack with no note is a mismatch
   always @(posedge clk) begin
      logic [32:0] e;
      if (od_rsp.ack === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            e = exp_q.pop_front();
            chk(od_rsp.abort, e[32]);
            chk(od_rsp.rdata, e[31:0]);
         end
      end
   end

   // ***************************************************************
   // bus tasks
   // ***************************************************************
   task automatic acc(input logic w, input logic r, input logic [15:0] idx,
                      input logic [7:0] sub, input logic [31:0] d,
                      input logic ab, input logic [31:0] ex);
      exp_q.push_back({ab, ex});
      @(posedge clk);
      mst.put(w, r, idx, sub, d);
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
      acc(1'b1, 1'b0, idx, sub, d, 1'b0, 32'h0);
   endtask

   task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] ex);
      acc(1'b0, 1'b1, idx, sub, 32'h0, 1'b0, ex);
   endtask

   task automatic idle();
      @(posedge clk);
      mst.idle();
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   initial begin
      logic [31:0] v, w, po, vo;
      logic [15:0] to;
      logic [4:0] m;
      logic [31:0] jv [4];
      mppb_setv_t sv;
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int i = 0; i < 4; i++) chk(jerk[i], RST_JERK);
      chk(pos_unit, 32'hff41_0000);
      chk(vel_unit, 32'h00b4_4700);
      chk(time_val, 8'h01);
      chk(time_idx, 8'hfd);
      chk(bank_ready, 1'b0);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      mst.put(1'b1, 1'b0, IDX_JERK, SUB_FIRST, 32'h0);
      idle();
      @(negedge clk);
      chk(bank_ready, 1'b1);
      chk(jerk[0], 32'h0000_03e8);
      chk(cycle_us, 32'd1000);
      chk(cycle_ok, 1'b1);
      // presets over the bus, one request per cycle
      rd(IDX_JERK, SUB_COUNT, 32'h4);
      for (int i = 1; i <= 4; i++) rd(IDX_JERK, 8'(i), 32'h0000_03e8);
      rd(IDX_POS_UNIT, SUB_COUNT, 32'hff41_0000);
      rd(IDX_VEL_UNIT, SUB_COUNT, 32'h00b4_4700);
      rd(IDX_POS_OFF, SUB_COUNT, 32'h0);
      rd(IDX_VEL_OFF, SUB_COUNT, 32'h0);
      rd(IDX_SETPT, SUB_COUNT, 32'h1);
      rd(IDX_TIME, SUB_COUNT, 32'h2);
      rd(IDX_TQ_OFF, SUB_COUNT, 32'h0);
      rd(IDX_SETPT, SUB_FIRST, 32'h0);
      rd(IDX_TIME, SUB_FIRST, 32'h1);
      rd(IDX_TIME, SUB_SECOND, 32'hffff_fffd);
      // jerk words, one forced to zero
      for (int i = 0; i < 4; i++) begin
         jv[i] = $random(seed);
         wr(IDX_JERK, 8'(i + 1), jv[i]);
      end
      jv[1] = 32'h0;
      wr(IDX_JERK, SUB_SECOND, 32'h0);
      for (int i = 0; i < 4; i++) rd(IDX_JERK, 8'(i + 1), jv[i]);
      idle();
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int i = 0; i < 4; i++) begin
         chk(jerk[i], jv[i]);
         chk(jerk_unlim[i], jv[i] == 32'h0);
      end
      // reserved unit bits stay zero; refused requests write nothing
      wr(IDX_POS_UNIT, SUB_COUNT, 32'hffff_ffff);
      rd(IDX_POS_UNIT, SUB_COUNT, 32'hffff_0000);
      wr(IDX_VEL_UNIT, SUB_COUNT, 32'hffff_ffff);
      rd(IDX_VEL_UNIT, SUB_COUNT, 32'hffff_ff00);
      acc(1'b1, 1'b0, 16'h6000, SUB_COUNT, 32'h1, 1'b1, 32'h0);
      acc(1'b1, 1'b0, IDX_JERK, SUB_COUNT, 32'h7, 1'b1, 32'h0);
      acc(1'b1, 1'b1, IDX_JERK, SUB_FIRST, 32'h5, 1'b1, 32'h0);
      acc(1'b0, 1'b1, IDX_POS_UNIT, SUB_FIRST, 32'h0, 1'b1, 32'h0);
      acc(1'b1, 1'b0, IDX_SETPT, SUB_COUNT, 32'h9, 1'b1, 32'h0);
      rd(IDX_JERK, SUB_FIRST, jv[0]);
      // offsets against every mode and an illegal code
      po = $random(seed);
      vo = $random(seed);
      v = $random(seed);
      to = v[15:0];
      wr(IDX_POS_OFF, SUB_COUNT, po);
      wr(IDX_VEL_OFF, SUB_COUNT, vo);
      wr(IDX_TQ_OFF, SUB_COUNT, v);
      rd(IDX_TQ_OFF, SUB_COUNT, {{16{to[15]}}, to});
      idle();
      foreach (modes[k]) begin
         m = modes[k];
         sv.pos = $random(seed);
         sv.vel = $random(seed);
         sv.tq = 16'($random(seed));
         @(posedge clk);
         set_in <= sv;
         op_mode <= mppb_mode_t'(m);
         @(posedge clk);
         @(negedge clk);
         chk(set_out.pos, sv.pos + (m == 5'h01 ? po : 32'h0));
         chk(set_out.vel, sv.vel + (m inside {5'h01, 5'h02, 5'h08} ? vo : 32'h0));
         chk(set_out.tq, 16'(sv.tq + (m inside {5'h01, 5'h02, 5'h04, 5'h08} ? to : 16'h0)));
      end
      // set-point only moves at a sync; a write beside the sync is too late
      v = $random(seed);
      w = $random(seed);
      wr(IDX_SETPT, SUB_FIRST, v);
      idle();
      @(negedge clk);
      chk(interp_target, 32'h0);
      wr(IDX_SETPT, SUB_FIRST, w);
      sync_evt <= 1'b1;
      idle();
      sync_evt <= 1'b0;
      @(negedge clk);
      chk(interp_target, v);
      rd(IDX_SETPT, SUB_FIRST, w);
      idle();
      @(posedge clk);
      sync_evt <= 1'b1;
      @(posedge clk);
      sync_evt <= 1'b0;
      @(negedge clk);
      chk(interp_target, w);
      // cycle time with the index held at minus three
      v = $random(seed);
      wr(IDX_TIME, SUB_FIRST, v);
      wr(IDX_TIME, SUB_SECOND, 32'h0000_0000);
      idle();
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(time_val, v[7:0]);
      chk(time_idx, 8'hfd);
      chk(cycle_us, v[7:0] * 1000);
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk);
      chk(exp_q.size(), 32'h0);
      // second reset in mid-run reloads presets
      @(posedge clk);
      rst_n <= 1'b0;
      @(negedge clk);
      chk(jerk[1], RST_JERK);
      chk(bank_ready, 1'b0);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(bank_ready, 1'b1);
      rd(IDX_JERK, SUB_SECOND, RST_JERK);
      idle();
      repeat (3) @(posedge clk);
      chk(exp_q.size(), 32'h0);
      test_done();
   end
endmodule
`default_nettype wire

// >>> test/mppb_master_model.sv
// fieldbus master model that places object requests on the bank's access port
`default_nettype none
module mppb_master_model
   import mppb_pkg::*;
(
   input wire logic clk,
   output mppb_pkg::mppb_req_t od_req
);
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************************
   // request lines
   // ***************************************************************
   mppb_req_t held = '0;
   logic busy = 1'b0;
   logic [31:0] noise = 32'h1234_5678;

   // released lines churn every cycle so a stale request never looks valid
   always @(posedge clk) noise <= {noise[30:0], noise[31] ^ noise[21]};
   assign od_req = busy ? held :
      mppb_req_t'{wr: 1'b0, rd: 1'b0, index: noise[15:0], sub: noise[23:16], wdata: ~noise};

   // called just after a rising edge; the pulse lasts until idle is called
   task automatic put(input logic w, input logic r, input logic [15:0] idx,
                      input logic [7:0] sub, input logic [31:0] d);
      if (w && idx == IDX_TIME && sub == 8'h02)
         d[7:0] = RST_TIME_IDX;
      held <= '{wr: w, rd: r, index: idx, sub: sub, wdata: d};
      busy <= 1'b1;
   endtask

   task automatic idle();
      busy <= 1'b0;
   endtask
endmodule
`default_nettype wire
